// File: logic/mcp_top.sv
// Purpose: Maintenance channel processor: operations-channel replies, latching, reporting
//          and validation of the received overhead bits.
// Assumes: Frame side logic runs on clk; rxFrameValid and rxOhValid are one-cycle pulses.
// Notes: AHB-Lite slave with zero wait states.
// Functional notes
// - Auto mode echoes frames for address 000/111 straight back as acknowledgement.
// - Auto mode answers foreign addresses with a hold message addressed 000.
// - Auto mode replies unable-to-comply after three bad frames in a row.
// - Valid commands latch together until return-to-normal, deactivation or leaving auto mode.
// - Auto mode reports a threefold confirmed new frame whatever its address.
// - A confirmed frame equal to the last confirmed one is not reported.
// - Auto execution only for address 000/111, flag 1, confirmed, defined.
// - Plain transparent mode reports every frame and never latches or executes.
// - Transparent modes transmit the transmit word last written by the host.
// - On-change mode reports only frames differing from the previous one.
// - Confirmed mode reports only after three equal consecutive new frames.
// - Each group-four bit has its own filter before reaching the host.
// - Filters: on change, threefold, checksum, or checksum and threefold.
// - Spare bits are not checksum covered; group-four bits are.
// - Activation bits reach the state machine threefold confirmed by default.
// - A config bit makes the state machine use the host filters.
// - Before activation state machine bits read link 0, shutdown 1, line-only 0.
// - A frame holds a 3-bit address, data/message flag and 8-bit code.
// - Unable-to-comply uses code AA and hold uses code 00.
// - Return-to-normal FF releases all latches and resets the transmit word.
// - Loop codes 50, 51, 52, corrupt request 53, corrupt notice 54.
`timescale 1ns/100ps
`include "mcp_regs.svh"

module mcp_top
  import mcp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic linkActive,
  input wire logic rxFrameValid,
  input wire mcp_frame_s rxFrame,
  input wire logic rxOhValid,
  input wire logic rxCrcOk,
  input wire logic [3:0] rxGroupFour,
  input wire logic [2:0] rxSpare,
  output mcp_frame_s txWord,
  output mcp_cmd_s cmdActive,
  output logic eocReport,
  output logic overheadReport,
  output logic [3:0] groupFourValid,
  output logic [2:0] spareValid,
  output logic [2:0] smBits
);

  // Reset is released through two flip-flops; everything else uses rstn.
  logic [1:0] rstPipe;
  logic rstn;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstn = rstPipe[1];

  // Information codes the terminal understands; used by reply and execution paths.
  function automatic logic isDefined(input logic [7:0] code);
    isDefined = (code == `MCP_CODE_HOLD) || (code == `MCP_CODE_RTN) ||
                (code >= `MCP_CODE_FULL_LOOP && code <= `MCP_CODE_NOTIFY_CORRUPT);
  endfunction

  // Filter decision for one bit; a change is always required.
  function automatic logic filterPass(input mcp_filt_e f, input logic diff, input logic threefold_confirm,
                                      input logic crc);
    case (f)
      MCP_FILT_CHANGE: filterPass = diff;
      MCP_FILT_TLL: filterPass = diff && threefold_confirm;
      MCP_FILT_CRC: filterPass = diff && crc;
      MCP_FILT_BOTH: filterPass = diff && threefold_confirm && crc;
      default: filterPass = 1'b0;
    endcase
  endfunction

  // Software-visible state.
  logic [`MCP_CFG_WIDTH-1:0] cfgReg;
  mcp_frame_s rxMsg;
  logic eocNew;
  logic overheadNew;

  // Bus address phase capture.
  logic wrPend;
  logic [4:0] wrOff;
  wire accept = hsel && htrans[1] && hready;
  wire rdAccept = accept && !hwrite;
  wire [4:0] accOff = {haddr[4:2], 2'h0};
  wire cfgWrite = wrPend && wrOff == `MCP_OFF_CONFIG;
  wire txWrite = wrPend && wrOff == `MCP_OFF_TXWORD;
  wire rdRxMsg = rdAccept && accOff == `MCP_OFF_RXMSG;
  wire rdOverhead = rdAccept && accOff == `MCP_OFF_OVERHEAD;

  mcp_mode_e mode;
  wire smSame = cfgReg[`MCP_CFG_SMSAME_BIT];
  assign mode = mcp_mode_e'(cfgReg[`MCP_CFG_MODE_LSB +: 2]);
  wire isAuto = mode == MCP_AUTO;

  // Read data multiplexer; unmapped offsets read zero.
  wire [31:0] rdWord =
    (accOff == `MCP_OFF_CONFIG) ? {20'h0_0000, cfgReg} :
    (accOff == `MCP_OFF_TXWORD) ? {20'h0_0000, txWord} :
    (accOff == `MCP_OFF_RXMSG) ? {20'h0_0000, rxMsg} :
    (accOff == `MCP_OFF_OVERHEAD) ? {20'h0_0000, 2'h0, smBits, spareValid, groupFourValid} :
    (accOff == `MCP_OFF_STATUS) ? {24'h00_0000, eocNew, overheadNew, 1'b0, cmdActive} :
    32'h0000_0000;

  // Bus slave: reads are loaded at the address phase so data stand in the data phase.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wrPend <= 1'b0;
      wrOff <= 5'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= accept && hwrite;
      wrOff <= accOff;
      if (rdAccept) hrdata <= rdWord;
    end
  end

  // Configuration register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cfgReg <= `MCP_CFG_RESET;
    else if (cfgWrite) cfgReg <= hwdata[`MCP_CFG_WIDTH-1:0];
  end

  // Frame classification shared by every mode.
  mcp_frame_s prevFrame;
  mcp_frame_s lastConf;
  logic prevValid;
  logic confValid;
  logic [1:0] tllCnt;
  logic [1:0] badCnt;
  wire addrOk = rxFrame.addr == `MCP_ADDR_NT || rxFrame.addr == `MCP_ADDR_BCAST;
  wire defined = isDefined(rxFrame.info);
  wire sameAsPrev = prevValid && rxFrame == prevFrame;
  wire [1:0] next_tllCnt = !sameAsPrev ? 2'h1 :
                           (tllCnt == `MCP_TLL_COUNT) ? tllCnt : tllCnt + 2'h1;
  // A confirmed frame is new only if it differs from the last confirmed one.
  wire tllHit = next_tllCnt == `MCP_TLL_COUNT && (!confValid || rxFrame != lastConf);
  wire badFrame = addrOk && (!rxFrame.dm || !defined);
  wire [1:0] next_badCnt = !badFrame ? 2'h0 :
                           (badCnt == `MCP_TLL_COUNT) ? badCnt : badCnt + 2'h1;
  wire utcReply = badFrame && next_badCnt == `MCP_TLL_COUNT;
  wire execute = isAuto && tllHit && addrOk && rxFrame.dm && defined;
  wire execRtn = execute && rxFrame.info == `MCP_CODE_RTN;

  // Reply selection in auto mode.
  wire mcp_frame_s holdFrame = {`MCP_ADDR_NT, 1'b1, `MCP_CODE_HOLD};
  wire mcp_frame_s utcFrame = {`MCP_ADDR_NT, 1'b1, `MCP_CODE_UTC};
  wire mcp_frame_s autoReply = !addrOk ? holdFrame :
                               utcReply ? utcFrame : rxFrame;

  // Report decision per mode.
  wire reportNow = rxFrameValid && (
    (mode == MCP_AUTO && tllHit) ||
    (mode == MCP_TRANSP) ||
    (mode == MCP_ONCHANGE && !sameAsPrev) ||
    (mode == MCP_CONFIRMED && tllHit));

  // Frame history counters.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevFrame <= 12'h000;
      prevValid <= 1'b0;
      tllCnt <= 2'h0;
      badCnt <= 2'h0;
      lastConf <= 12'h000;
      confValid <= 1'b0;
    end else if (rxFrameValid) begin
      prevFrame <= rxFrame;
      prevValid <= 1'b1;
      tllCnt <= next_tllCnt;
      badCnt <= next_badCnt;
      if (tllHit) begin
        lastConf <= rxFrame;
        confValid <= 1'b1;
      end
    end
  end

  // Transmit word: auto replies overwrite the host's word; the frame wins a same-cycle write.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) txWord <= `MCP_TXWORD_RESET;
    else if (execRtn) txWord <= `MCP_TXWORD_RESET;
    else if (isAuto && rxFrameValid) txWord <= autoReply;
    else if (txWrite) txWord <= hwdata[11:0];
  end

  // Command latches; transparent modes hold them cleared, the host acts instead.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cmdActive <= 5'h00;
    else if (!linkActive || execRtn || !isAuto) cmdActive <= 5'h00;
    else if (execute) begin
      if (rxFrame.info == `MCP_CODE_FULL_LOOP) cmdActive.fullLoop <= 1'b1;
      if (rxFrame.info == `MCP_CODE_LOOP_B1) cmdActive.loopB1 <= 1'b1;
      if (rxFrame.info == `MCP_CODE_LOOP_B2) cmdActive.loopB2 <= 1'b1;
      if (rxFrame.info == `MCP_CODE_REQ_CORRUPT) cmdActive.reqCorrupt <= 1'b1;
      if (rxFrame.info == `MCP_CODE_NOTIFY_CORRUPT) cmdActive.notifyCorrupt <= 1'b1;
    end
  end

  // Received-message register and report flags; a new report wins over a read clear.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxMsg <= 12'h000;
      eocReport <= 1'b0;
      eocNew <= 1'b0;
    end else begin
      eocReport <= reportNow;
      if (reportNow) rxMsg <= rxFrame;
      if (reportNow) eocNew <= 1'b1;
      else if (rdRxMsg) eocNew <= 1'b0;
    end
  end

  // Per-bit group-four filtering; bits 0..2 also feed the activation state machine.
  logic [3:0] m4Last;
  logic [7:0] m4Cnt;
  logic [7:0] next_m4Cnt;
  logic [3:0] next_m4Valid;
  logic [2:0] next_smBits;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : genBit
      wire mcp_filt_e hostFilt = mcp_filt_e'(cfgReg[`MCP_CFG_FILT_LSB + 2*gi +: 2]);
      wire [1:0] cnt = m4Cnt[2*gi +: 2];
      wire same = rxGroupFour[gi] == m4Last[gi];
      assign next_m4Cnt[2*gi +: 2] = !same ? 2'h1 : (cnt == `MCP_TLL_COUNT) ? cnt : cnt + 2'h1;
      wire threefold_confirm = next_m4Cnt[2*gi +: 2] == `MCP_TLL_COUNT;
      wire hostPass = filterPass(hostFilt, rxGroupFour[gi] != groupFourValid[gi], threefold_confirm,
                                 rxCrcOk);
      assign next_m4Valid[gi] = hostPass ? rxGroupFour[gi] : groupFourValid[gi];
      if (gi < 3) begin : genSm
        wire mcp_filt_e smFilt = smSame ? hostFilt : MCP_FILT_TLL;
        wire smPass = filterPass(smFilt, rxGroupFour[gi] != smBits[gi], threefold_confirm, rxCrcOk);
        assign next_smBits[gi] = smPass ? rxGroupFour[gi] : smBits[gi];
      end
    end
  endgenerate

  // Overhead registers; the spare bits are taken on change, not gated by the checksum.
  wire ohChange = rxOhValid && (next_m4Valid != groupFourValid || rxSpare != spareValid);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m4Last <= 4'h0;
      m4Cnt <= 8'h00;
      groupFourValid <= 4'h0;
      spareValid <= 3'h0;
      smBits <= `MCP_SM_RESET;
      overheadReport <= 1'b0;
      overheadNew <= 1'b0;
    end else begin
      overheadReport <= ohChange;
      if (ohChange) overheadNew <= 1'b1;
      else if (rdOverhead) overheadNew <= 1'b0;
      if (rxOhValid) begin
        m4Last <= rxGroupFour;
        m4Cnt <= next_m4Cnt;
        groupFourValid <= next_m4Valid;
        spareValid <= rxSpare;
      end
      if (!linkActive) smBits <= `MCP_SM_RESET;
      else if (rxOhValid) smBits <= next_smBits;
    end
  end

  // Checks next to the logic they guard.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seqAutoFrame;
    isAuto && rxFrameValid;
  endsequence
  sequence seqHostTxWrite;
    txWrite && !isAuto;
  endsequence

  AST_AUTO_ECHO: assert property (seqAutoFrame ##0 (addrOk && !utcReply && !execRtn)
    |=> txWord == $past(rxFrame)) else $error("Auto echo missing.");
  AST_HOLD_REPLY: assert property (seqAutoFrame ##0 !addrOk
    |=> txWord == {3'h0, 1'b1, 8'h00}) else $error("Hold reply wrong.");
  AST_UTC_THIRD: assert property (seqAutoFrame ##0 (badFrame && badCnt == 2'h2)
    |=> txWord.info == 8'hAA) else $error("Unable-to-comply not sent.");
  AST_LATCH_STAYS: assert property (cmdActive.fullLoop && linkActive && isAuto && !execRtn
    |=> cmdActive.fullLoop) else $error("Latched command dropped.");
  AST_CONFIRM_REPORT: assert property (seqAutoFrame ##0 tllHit
    |=> eocReport && rxMsg == $past(rxFrame)) else $error("Confirmed frame not reported.");
  AST_NO_REPEAT: assert property (rxFrameValid && (isAuto || mode == MCP_CONFIRMED) &&
    confValid && rxFrame == lastConf |=> !eocReport) else $error("Repeat reported.");
  AST_PLAIN_ALL: assert property (mode == MCP_TRANSP && rxFrameValid
    |=> eocReport ##1 cmdActive == 5'h00) else $error("Plain mode report or latch wrong.");
  AST_HOST_WORD: assert property (seqHostTxWrite ##0 !execRtn
    |=> txWord == $past(hwdata[11:0])) else $error("Host word not sent.");
  AST_ONCHANGE: assert property (mode == MCP_ONCHANGE && rxFrameValid && sameAsPrev
    |=> !eocReport) else $error("On-change reported a repeat.");
  AST_SM_IDLE: assert property (!linkActive |=> smBits == 3'h2)
    else $error("State machine bits not at reset values.");
  AST_CRC_GATE: assert property (rxOhValid && !rxCrcOk &&
    cfgReg[`MCP_CFG_FILT_LSB +: 2] == 2'h2 |=> $stable(groupFourValid[0]))
    else $error("Checksum filter let a bad frame through.");

  // Confirmed mode: a frame unlike its predecessor can never complete a confirmation.
  AST_CONFIRMED_WAIT: assert property (mode == MCP_CONFIRMED && rxFrameValid && !sameAsPrev
    |=> !eocReport) else $error("Confirmed mode reported an unconfirmed frame.");
  // Foreign or data frames never execute, so an idle latch set stays idle behind them.
  AST_NO_FOREIGN_EXEC: assert property (rxFrameValid && (!addrOk || !rxFrame.dm) &&
    cmdActive == 5'h00 |=> cmdActive == 5'h00) else $error("Foreign frame executed.");
  // Return-to-normal and deactivation release every latch; the former also resets the word.
  AST_RTN_RELEASE: assert property (execRtn
    |=> cmdActive == 5'h00 && txWord == 12'h1FF) else $error("Return-to-normal not applied.");
  AST_DEACT_RELEASE: assert property (!linkActive |=> cmdActive == 5'h00)
    else $error("Deactivation kept a latch.");
  // By default the state machine link-up bit only moves on a third equal superframe.
  AST_SM_THREEFOLD: assert property (linkActive && !smSame && rxOhValid &&
    next_m4Cnt[1:0] != 2'h3 |=> $stable(smBits[0]))
    else $error("State machine bit moved unconfirmed.");
  // No host report is raised when neither the validated nor the spare bits move.
  AST_OH_QUIET: assert property (rxOhValid && next_m4Valid == groupFourValid &&
    rxSpare == spareValid |=> !overheadReport) else $error("Overhead report without change.");

endmodule

// File: logic/mcp_regs.svh
// Purpose: Register offsets, field positions, reset values and codes of the maintenance channel processor.
// Assumes: Included by the design file; definitions only.
// Notes: Byte offsets on the 32-bit AHB-Lite slave, one aligned word per register.
`ifndef MCP_REGS_SVH
`define MCP_REGS_SVH

// Register byte offsets.
`define MCP_OFF_CONFIG 5'h00
`define MCP_OFF_TXWORD 5'h04
`define MCP_OFF_RXMSG 5'h08
`define MCP_OFF_OVERHEAD 5'h0C
`define MCP_OFF_STATUS 5'h10

// CONFIG fields: channel mode, state machine filter select, four 2-bit bit filters.
`define MCP_CFG_MODE_LSB 0
`define MCP_CFG_SMSAME_BIT 2
`define MCP_CFG_FILT_LSB 4
`define MCP_CFG_WIDTH 12
`define MCP_CFG_RESET 12'h000

// Reset values of the transmit word and the state machine bits.
`define MCP_TXWORD_RESET 12'h1FF
`define MCP_SM_RESET 3'h2

// Information codes of the channel.
`define MCP_CODE_HOLD 8'h00
`define MCP_CODE_FULL_LOOP 8'h50
`define MCP_CODE_LOOP_B1 8'h51
`define MCP_CODE_LOOP_B2 8'h52
`define MCP_CODE_REQ_CORRUPT 8'h53
`define MCP_CODE_NOTIFY_CORRUPT 8'h54
`define MCP_CODE_UTC 8'hAA
`define MCP_CODE_RTN 8'hFF

// Addresses of the terminal and broadcast, and the confirmation count.
`define MCP_ADDR_NT 3'h0
`define MCP_ADDR_BCAST 3'h7
`define MCP_TLL_COUNT 2'h3

`endif

// File: logic/mcp_pkg.sv
// Purpose: Types shared by the maintenance channel processor.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Codes and offsets live in mcp_regs.svh.
package mcp_pkg;

  // One operations-channel frame: address, data/message flag, information.
  typedef struct packed {
    logic [2:0] addr;
    logic dm;
    logic [7:0] info;
  } mcp_frame_s;

  // Commands held active in auto mode.
  typedef struct packed {
    logic fullLoop;
    logic loopB1;
    logic loopB2;
    logic reqCorrupt;
    logic notifyCorrupt;
  } mcp_cmd_s;

  // Channel modes, Gray ordered.
  typedef enum logic [1:0] {
    MCP_AUTO = 2'h0,
    MCP_TRANSP = 2'h1,
    MCP_ONCHANGE = 2'h3,
    MCP_CONFIRMED = 2'h2
  } mcp_mode_e;

  // Per-bit validation filters of the group-four bits.
  typedef enum logic [1:0] {
    MCP_FILT_CHANGE = 2'h0,
    MCP_FILT_TLL = 2'h1,
    MCP_FILT_CRC = 2'h2,
    MCP_FILT_BOTH = 2'h3
  } mcp_filt_e;

endpackage

// File: test/mcp_far_end.sv
// Purpose: Far-end model: line frames and overhead superframes from the exchange.
// Assumes: The bench calls the tasks; signals change just after a rising edge.
// Notes: Outside a pulse the data lines carry the inverse of the last value.
`timescale 1ns/100ps
module mcp_far_end
  import mcp_pkg::*;
(
  input wire logic clk,
  output logic rxFrameValid,
  output mcp_frame_s rxFrame,
  output logic rxOhValid,
  output logic rxCrcOk,
  output logic [3:0] rxGroupFour,
  output logic [2:0] rxSpare
);
  // Idle levels at time zero, so that nothing looks like a pulse.
  initial begin
    rxFrameValid = 1'b0;
    rxFrame = '0;
    rxOhValid = 1'b0;
    rxCrcOk = 1'b0;
    rxGroupFour = 4'h0;
    rxSpare = 3'h0;
  end
  // One frame; an idle cycle follows, so calls in a row stay separate pulses.
  task automatic sendFrame(input mcp_frame_s f);
    @(posedge clk);
    rxFrameValid <= 1'b1;
    rxFrame <= f;
    @(posedge clk);
    rxFrameValid <= 1'b0;
    rxFrame <= ~f;
  endtask
  // One superframe with its checksum verdict; spare bits ride outside the checksum.
  task automatic sendOh(input logic crc, input logic [3:0] g4, input logic [2:0] sp);
    @(posedge clk);
    rxOhValid <= 1'b1;
    rxCrcOk <= crc;
    rxGroupFour <= g4;
    rxSpare <= sp;
    @(posedge clk);
    rxOhValid <= 1'b0;
    rxCrcOk <= ~crc;
    rxGroupFour <= ~g4;
    rxSpare <= ~sp;
  endtask
endmodule

// File: test/maintenance_channel_processor_test.sv
// Purpose: Self-checking bench of the maintenance channel processor.
// Assumes: Zero wait state slave; frame results appear the cycle after the pulse.
// Notes: Drivers queue expectations; monitors pop them when a result appears.
`timescale 1ns/100ps
`include "mcp_regs.svh"
module maintenance_channel_processor_test
  import mcp_pkg::*;
;
  logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, rdPhase, linkActive;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic rxFrameValid, rxOhValid, rxCrcOk, eocReport, overheadReport, frameTaken, ohTaken;
  mcp_frame_s rxFrame, txWord, p1, p2, lastConf;
  mcp_cmd_s cmdActive, cmdExp;
  logic [3:0] rxGroupFour, groupFourValid;
  logic [2:0] rxSpare, spareValid, smBits;
  logic [11:0] hostWord;
  logic [31:0] rdQ[$], frQ[$], ohQ[$];
  mcp_mode_e mode;
  int fail_count, n_checks, cycles, badRun;
  assign hready = hreadyout;
  mcp_top u_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .linkActive(linkActive),
    .rxFrameValid(rxFrameValid), .rxFrame(rxFrame), .rxOhValid(rxOhValid),
    .rxCrcOk(rxCrcOk), .rxGroupFour(rxGroupFour), .rxSpare(rxSpare), .txWord(txWord),
    .cmdActive(cmdActive), .eocReport(eocReport), .overheadReport(overheadReport),
    .groupFourValid(groupFourValid), .spareValid(spareValid), .smBits(smBits));
  mcp_far_end u_far (.clk(clk), .rxFrameValid(rxFrameValid), .rxFrame(rxFrame),
    .rxOhValid(rxOhValid), .rxCrcOk(rxCrcOk), .rxGroupFour(rxGroupFour), .rxSpare(rxSpare));
  // 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counts every comparison; a mismatch is printed at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The single place where the run ends.
  task automatic results;
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One single AHB-Lite word transfer; a read queues its expected data.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    if (!wr) rdQ.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    rdPhase <= !wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdPhase <= 1'b0;
  endtask
  // Works out reply, report and latches of one frame, then sends it.
  task automatic frame(input mcp_frame_s f);
    logic conf, good, defd, rep;
    mcp_frame_s tx;
    conf = (f === p1) && (f === p2) && (f !== lastConf);
    good = f.addr == `MCP_ADDR_NT || f.addr == `MCP_ADDR_BCAST;
    defd = f.info == `MCP_CODE_HOLD || f.info == `MCP_CODE_RTN ||
      (f.info >= `MCP_CODE_FULL_LOOP && f.info <= `MCP_CODE_NOTIFY_CORRUPT);
    badRun = (good && (!f.dm || !defd)) ? badRun + 1 : 0;
    tx = hostWord;
    rep = (mode == MCP_TRANSP) || (mode == MCP_ONCHANGE && f !== p1);
    if (mode == MCP_AUTO || mode == MCP_CONFIRMED) rep = conf;
    if (mode == MCP_AUTO) begin
      tx = f;
      if (!good) tx = {`MCP_ADDR_NT, 1'b1, `MCP_CODE_HOLD};
      if (badRun >= 3) tx = {`MCP_ADDR_NT, 1'b1, `MCP_CODE_UTC};
      if (conf && good && f.dm) begin
        case (f.info)
          `MCP_CODE_FULL_LOOP: cmdExp.fullLoop = 1'b1;
          `MCP_CODE_LOOP_B1: cmdExp.loopB1 = 1'b1;
          `MCP_CODE_LOOP_B2: cmdExp.loopB2 = 1'b1;
          `MCP_CODE_REQ_CORRUPT: cmdExp.reqCorrupt = 1'b1;
          `MCP_CODE_NOTIFY_CORRUPT: cmdExp.notifyCorrupt = 1'b1;
          `MCP_CODE_RTN: begin
            cmdExp = '0;
            tx = `MCP_TXWORD_RESET;
          end
          default: ;
        endcase
      end
    end
    if (conf) lastConf = f;
    p2 = p1;
    p1 = f;
    frQ.push_back({14'h0, tx, rep, cmdExp});
    u_far.sendFrame(f);
  endtask
  // Queues {report, spare, group four, state machine bits} of one superframe.
  task automatic oh(input logic crc, input logic [3:0] g4, input logic [2:0] sp,
                    input logic [10:0] exp);
    ohQ.push_back({21'h0, exp});
    u_far.sendOh(crc, g4, sp);
  endtask
  // Monitors: results stand the cycle after the pulse; read data at the data phase end.
  always @(posedge clk) begin
    frameTaken <= rxFrameValid;
    ohTaken <= rxOhValid;
    cycles++;
    if (rdPhase && hreadyout) check("hrdata", rdQ.pop_front(), hrdata);
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  always @(negedge clk) begin
    if (frameTaken) check("frame", frQ.pop_front(), {14'h0, txWord, eocReport, cmdActive});
    if (ohTaken) check("overhead", ohQ.pop_front(),
      {21'h0, overheadReport, spareValid, groupFourValid, smBits});
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h0000_451d));
    {resetn, hsel, hwrite, rdPhase} = 4'h0;
    {htrans, haddr, hwdata} = '0;
    linkActive = 1'b1;
    {p1, p2, lastConf} = '1;
    {cmdExp, hostWord, badRun, cycles, fail_count, n_checks} = '0;
    mode = MCP_AUTO;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, {27'h0, `MCP_OFF_CONFIG}, 32'h0000_0000);
    bus(1'b0, {27'h0, `MCP_OFF_TXWORD}, {20'h0, `MCP_TXWORD_RESET});
    bus(1'b0, {27'h0, `MCP_OFF_OVERHEAD}, {22'h0, `MCP_SM_RESET, 7'h0});
    bus(1'b1, {27'h0, `MCP_OFF_RXMSG}, 32'h0000_0abc);
    bus(1'b0, {27'h0, `MCP_OFF_RXMSG}, 32'h0000_0000);
    bus(1'b0, 32'h0000_0014, 32'h0000_0000);
    // Overhead filters: change, then checksum on bit 2 and threefold on bit 3.
    oh(1'b1, 4'h3, 3'h5, {1'b1, 3'h5, 4'h3, 3'h2});
    oh(1'b1, 4'h3, 3'h5, {1'b0, 3'h5, 4'h3, 3'h2});
    oh(1'b1, 4'h3, 3'h5, {1'b0, 3'h5, 4'h3, 3'h3});
    bus(1'b1, {27'h0, `MCP_OFF_CONFIG}, 32'h0000_0600);
    oh(1'b0, 4'hF, 3'h2, {1'b1, 3'h2, 4'h3, 3'h3});
    oh(1'b1, 4'hF, 3'h2, {1'b1, 3'h2, 4'h7, 3'h3});
    oh(1'b1, 4'hF, 3'h2, {1'b1, 3'h2, 4'hF, 3'h7});
    // Auto mode: every loop code latched in turn, then a repeat, foreign and bad frames.
    for (int c = 0; c < 5; c++) begin
      repeat (3) frame({c[0] ? 3'h7 : 3'h0, 1'b1, 8'h50 + 8'(c)});
    end
    repeat (3) frame({3'h0, 1'b1, `MCP_CODE_NOTIFY_CORRUPT});
    repeat (3) frame({3'h3, 1'b1, `MCP_CODE_LOOP_B2});
    repeat (3) frame({3'h0, 1'b0, `MCP_CODE_REQ_CORRUPT});
    repeat (3) frame({3'h0, 1'b1, 8'h33});
    repeat (3) frame({3'h0, 1'b1, `MCP_CODE_RTN});
    // Plain transparent: the host word goes out and every frame is reported.
    mode = MCP_TRANSP;
    bus(1'b1, {27'h0, `MCP_OFF_CONFIG}, 32'h0000_0601);
    rnd = $urandom;
    hostWord = rnd[11:0];
    bus(1'b1, {27'h0, `MCP_OFF_TXWORD}, {20'h0, hostWord});
    repeat (6) begin
      rnd = $urandom;
      frame(rnd[11:0]);
    end
    bus(1'b0, {27'h0, `MCP_OFF_RXMSG}, {20'h0, p1});
    mode = MCP_ONCHANGE;
    bus(1'b1, {27'h0, `MCP_OFF_CONFIG}, 32'h0000_0603);
    frame({3'h3, 1'b1, 8'h52});
    frame({3'h0, 1'b1, 8'h50});
    frame({3'h0, 1'b1, 8'h51});
    frame({3'h0, 1'b1, 8'h51});
    mode = MCP_CONFIRMED;
    bus(1'b1, {27'h0, `MCP_OFF_CONFIG}, 32'h0000_0602);
    repeat (4) frame({3'h3, 1'b1, 8'h52});
    repeat (3) frame({3'h0, 1'b1, 8'h50});
    repeat (3) frame({3'h0, 1'b1, 8'h51});
    // Deactivation puts the state machine bits back to their idle values.
    @(posedge clk);
    linkActive <= 1'b0;
    oh(1'b1, 4'hF, 3'h2, {1'b0, 3'h2, 4'hF, 3'h2});
    // Sticky report flags: both set, then reading the overhead word clears only its own.
    bus(1'b0, {27'h0, `MCP_OFF_STATUS}, 32'h0000_00C0);
    bus(1'b0, {27'h0, `MCP_OFF_OVERHEAD}, 32'h0000_012F);
    bus(1'b0, {27'h0, `MCP_OFF_STATUS}, 32'h0000_0080);
    repeat (3) @(posedge clk);
    results();
  end
endmodule
